// ---- rtl/obcl_loader.sv ----
// Purpose: Reads option bytes from flash after reset and holds the configuration
// Assumes: Flash answers a request with rd_valid any number of cycles later
// Notes: Boot swap copy of the threshold byte is requested through the write port
`timescale 1ns/10ps
`default_nettype none
module obcl_loader
    import obcl_pkg::*;
(
    input wire logic core_clk,
    input wire logic rstn,
    input wire logic boot_swap,
    input wire logic ext_programmer,
    input wire logic rd_valid,
    input wire logic [7:0] rd_data,
    output obcl_req_t rd_req,
    output logic wr_req,
    output logic [15:0] wr_addr,
    output logic [7:0] wr_data,
    output obcl_cfg_t cfg,
    output logic cfg_ready,
    output logic reserved_error,
    output logic poc_write_reject
);
    typedef enum {OBCL_IDLE, OBCL_REQ, OBCL_WAIT, OBCL_COPY, OBCL_DONE} obcl_state_t;
    obcl_state_t state, next_state;
    logic [2:0] idx, next_idx; // Byte being fetched
    logic sw, next_sw; // Swap latched at start of load
    obcl_req_t next_rd_req; // Next read request
    logic next_wr_req; // Next copy pulse
    logic [7:0] next_wr_data; // Byte to copy
    obcl_cfg_t next_cfg; // Next held configuration
    logic next_cfg_ready; // Load finished
    logic next_reserved_error; // Sticky reserved byte flag
    logic next_poc_write_reject; // Refused copy pulse
    logic [15:0] base; // First address of the active bank
    logic sw_meta; // Boot swap, first stage
    logic sw_sync; // Boot swap, safe to read
    logic prog_meta; // Programmer present, first stage
    logic prog_sync; // Programmer present, safe to read

    // Size of the option area must agree with the index of its last byte
    if (int'(OBCL_IDX_LAST) != OBCL_NUM_BYTES - 1) begin : g_bad_area
        $error("option area size and last index disagree");
    end

    // Two-stage synchronisers for the pin levels; they run on through reset so that
    // the boot swap level has settled by the first edge after release. A reset shorter
    // than two clocks may therefore load with the level seen before it.
    always_ff @(posedge core_clk) begin
        sw_meta <= boot_swap;
        sw_sync <= sw_meta;
        prog_meta <= ext_programmer;
        prog_sync <= prog_meta;
    end

    assign base = sw ? OBCL_BASE_SWAP : OBCL_BASE_NORMAL;

    // Load sequencer next state
    always_comb begin
        next_state = state;
        next_idx = idx;
        next_sw = sw;
        next_rd_req = '{valid: 1'b0, addr: rd_req.addr};
        next_wr_req = 1'b0;
        next_wr_data = wr_data;
        next_cfg = cfg;
        next_cfg_ready = cfg_ready;
        next_reserved_error = reserved_error;
        next_poc_write_reject = 1'b0;
        unique case (state)
            OBCL_IDLE: begin
                // Start load right after reset release
                next_sw = sw_sync;
                next_idx = 3'h0;
                next_state = OBCL_REQ;
            end
            OBCL_REQ: begin
                // Issue one read
                next_rd_req.valid = 1'b1;
                next_rd_req.addr = base + {13'h0000, idx};
                next_state = OBCL_WAIT;
            end
            OBCL_WAIT: begin
                if (rd_valid) begin
                    unique case (idx)
                        3'h0: begin
                            // First byte: oscillator and watchdog
                            next_cfg.lso_stoppable = rd_data[OBCL_LSO_BIT];
                            next_cfg.wdt_overflow = rd_data[OBCL_WDT_OVF_LSB +: 3];
                            next_cfg.wdt_enable = rd_data[OBCL_WDT_EN_BIT];
                            next_cfg.wdt_window = rd_data[OBCL_WDT_WIN_LSB +: 2];
                        end
                        3'h1: begin
                            // Threshold mode; one = 2.7 V release, zero = 1.59 V
                            next_cfg.poc_threshold_select = rd_data[OBCL_POC_BIT];
                            next_wr_data = rd_data;
                        end
                        3'h2, 3'h3: begin
                            // Reserved bytes must be zero
                            if (rd_data != OBCL_RESERVED_VAL) begin
                                next_reserved_error = 1'b1;
                            end
                        end
                        default: begin
                            // Last byte carries nothing here
                        end
                    endcase
                    if (idx == OBCL_IDX_LAST) begin
                        next_state = sw ? OBCL_COPY : OBCL_DONE;
                    end else begin
                        next_idx = idx + 3'h1;
                        next_state = OBCL_REQ;
                    end
                end
            end
            OBCL_COPY: begin
                // Copy swapped threshold byte into normal location
                if (prog_sync) begin
                    next_wr_req = 1'b1;
                end else begin
                    next_poc_write_reject = 1'b1;
                end
                next_state = OBCL_DONE;
            end
            OBCL_DONE: begin
                // Configuration held until next reset
                next_cfg_ready = 1'b1;
            end
        endcase
    end

    // Register the sequencer
    always_ff @(posedge core_clk or negedge rstn) begin
        if (!rstn) begin
            state <= OBCL_IDLE;
            idx <= 3'h0;
            sw <= 1'b0;
            rd_req <= '0;
            wr_req <= 1'b0;
            wr_addr <= OBCL_ADDR_POC;
            wr_data <= OBCL_CFG1_RST;
            cfg <= '0;
            cfg_ready <= 1'b0;
            reserved_error <= 1'b0;
            poc_write_reject <= 1'b0;
        end else begin
            state <= next_state;
            idx <= next_idx;
            sw <= next_sw;
            rd_req <= next_rd_req;
            wr_req <= next_wr_req;
            wr_addr <= OBCL_ADDR_POC;
            wr_data <= next_wr_data;
            cfg <= next_cfg;
            cfg_ready <= next_cfg_ready;
            reserved_error <= next_reserved_error;
            poc_write_reject <= next_poc_write_reject;
        end
    end

    // Steps of a load, shared by the properties below
    sequence s_byte_taken;
        state == OBCL_WAIT && rd_valid;
    endsequence
    sequence s_last_taken;
        s_byte_taken ##0 idx == OBCL_IDX_LAST;
    endsequence

    // Held config never changes once ready
    a_cfg_held_stable: assert property (@(posedge core_clk) disable iff (!rstn)
        cfg_ready |=> $stable(cfg))
        else $error("config changed after load");
    // Reads stay inside the bank chosen at load start
    a_swap_read_addr: assert property (@(posedge core_clk) disable iff (!rstn)
        rd_req.valid && sw |-> rd_req.addr[15:3] == OBCL_BASE_SWAP[15:3])
        else $error("swap read outside swap area");
    a_normal_read_addr: assert property (@(posedge core_clk) disable iff (!rstn)
        rd_req.valid && !sw |-> rd_req.addr[15:3] == OBCL_BASE_NORMAL[15:3])
        else $error("read outside option area");
    // Each taken byte except the last is followed two cycles later by the read of the next address
    a_next_read_step: assert property (@(posedge core_clk) disable iff (!rstn)
        s_byte_taken ##0 idx != OBCL_IDX_LAST |->
        ##2 rd_req.valid && rd_req.addr == $past(rd_req.addr) + 16'h0001)
        else $error("next option byte not requested");
    // Threshold copy only with the programmer attached, and only on boot swap
    a_copy_needs_prog: assert property (@(posedge core_clk) disable iff (!rstn)
        wr_req |-> prog_sync || $past(prog_sync))
        else $error("threshold write without programmer");
    a_reject_no_prog: assert property (@(posedge core_clk) disable iff (!rstn)
        poc_write_reject |-> sw && !$past(prog_sync))
        else $error("copy refused with programmer present");
    a_copy_only_swap: assert property (@(posedge core_clk) disable iff (!rstn)
        wr_req |-> sw && wr_addr == OBCL_ADDR_POC)
        else $error("copy without boot swap");
    a_copy_data: assert property (@(posedge core_clk) disable iff (!rstn)
        wr_req |-> wr_data[OBCL_POC_BIT] == cfg.poc_threshold_select)
        else $error("copied byte differs from loaded threshold");
    // Load starts right after reset release and ends in one of two ways
    a_first_read_soon: assert property (@(posedge core_clk) disable iff (!rstn)
        $rose(rstn) |-> ##[0:4] rd_req.valid)
        else $error("load did not start");
    a_swap_copy_step: assert property (@(posedge core_clk) disable iff (!rstn)
        s_last_taken ##0 sw |-> ##2 (wr_req != poc_write_reject) ##1 cfg_ready)
        else $error("boot swap copy step missing");
    a_normal_done_step: assert property (@(posedge core_clk) disable iff (!rstn)
        s_last_taken ##0 !sw |-> ##2 cfg_ready && !wr_req && !poc_write_reject)
        else $error("load did not finish");
    // Loaded fields come from the byte taken on the previous edge
    a_poc_from_byte: assert property (@(posedge core_clk) disable iff (!rstn)
        s_byte_taken ##0 idx == 3'h1 |=>
        cfg.poc_threshold_select == $past(rd_data[OBCL_POC_BIT]))
        else $error("threshold bit not loaded");
    a_wdt_from_byte: assert property (@(posedge core_clk) disable iff (!rstn)
        s_byte_taken ##0 idx == 3'h0 |=>
        cfg.wdt_enable == $past(rd_data[OBCL_WDT_EN_BIT]))
        else $error("watchdog enable not loaded");
    a_lso_from_byte: assert property (@(posedge core_clk) disable iff (!rstn)
        s_byte_taken ##0 idx == 3'h0 |=>
        cfg.lso_stoppable == $past(rd_data[OBCL_LSO_BIT]))
        else $error("oscillator choice not loaded");
    a_reserved_flag: assert property (@(posedge core_clk) disable iff (!rstn)
        s_byte_taken ##0 (idx == 3'h2 || idx == 3'h3) ##0 rd_data != OBCL_RESERVED_VAL
        |=> reserved_error)
        else $error("reserved byte not flagged");
endmodule // obcl_loader
`default_nettype wire

// ---- pkg/obcl_pkg.sv ----
// Purpose: Constants and types for the option byte configuration loader
// Assumes: Byte-wide flash read port with variable read latency handshake
// Notes: Bit positions inside the first two option bytes are a local choice
// Summary of operation
// - Option area is flash bytes 0080H..0084H
// - Reload option bytes after every reset release
// - Boot swap fetches from 1080H..1084H instead
// - First byte selects low-speed oscillator stoppability
// - First byte sets watchdog interval, enable, window
// - Threshold bit one: release 2.7 V, detect 1.59 V
// - Threshold bit zero: 1.59 V both ways
// - Threshold bit changes only via external programmer
// - Boot swap copies swapped second byte to normal, only with the external programmer attached
package obcl_pkg;
    localparam logic [15:0] OBCL_BASE_NORMAL = 16'h0080;
    localparam logic [15:0] OBCL_BASE_SWAP = 16'h1080;
    localparam logic [15:0] OBCL_ADDR_POC = 16'h0081;
    localparam int OBCL_NUM_BYTES = 5;
    localparam logic [2:0] OBCL_IDX_LAST = 3'h4;
    localparam logic [7:0] OBCL_RESERVED_VAL = 8'h00;
    // Field positions inside the first two option bytes
    localparam int OBCL_LSO_BIT = 0;
    localparam int OBCL_WDT_OVF_LSB = 1;
    localparam int OBCL_WDT_EN_BIT = 4;
    localparam int OBCL_WDT_WIN_LSB = 5;
    localparam int OBCL_POC_BIT = 0;
    // Reset values of the held configuration
    localparam logic [7:0] OBCL_CFG0_RST = 8'h00;
    localparam logic [7:0] OBCL_CFG1_RST = 8'h00;
    // Decoded configuration
    typedef struct packed {
        logic lso_stoppable;
        logic [2:0] wdt_overflow;
        logic wdt_enable;
        logic [1:0] wdt_window;
        logic poc_threshold_select;
    } obcl_cfg_t;
    // Flash read request
    typedef struct packed {
        logic valid;
        logic [15:0] addr;
    } obcl_req_t;
endpackage

// ---- tb/obcl_flash.sv ----
// Purpose: Behavioural flash holding both option byte banks
// Assumes: One read outstanding, answer after lat extra cycles
// Notes: Data line toggles when no answer stands on it
`timescale 1ns/10ps
`default_nettype none
module obcl_flash
    import obcl_pkg::*;
(
    input wire logic core_clk,
    input wire logic rstn,
    input wire obcl_req_t rd_req,
    input wire logic [3:0] lat,
    output logic rd_valid = 1'b0,
    output logic [7:0] rd_data = 8'hA5
);
    logic [7:0] mem [2][5]; // Bank 1 is the swapped area
    logic [3:0] cnt = 4'h0;
    logic busy = 1'b0;
    logic [15:0] addr = 16'h0000;
    // Accept one read, wait, then answer for a single cycle
    always @(posedge core_clk or negedge rstn) begin
        if (!rstn) begin
            busy <= 1'b0;
            rd_valid <= 1'b0;
        end else begin
            rd_valid <= 1'b0;
            rd_data <= ~rd_data; // Released line shows no stale byte
            if (rd_req.valid) begin
                busy <= 1'b1;
                cnt <= lat;
                addr <= rd_req.addr;
            end else if (busy && cnt != 4'h0) begin
                cnt <= cnt - 4'h1;
            end else if (busy) begin
                busy <= 1'b0;
                rd_valid <= 1'b1;
                rd_data <= mem[addr[12]][addr[2:0]];
            end
        end
    end
endmodule // obcl_flash
`default_nettype wire

// ---- tb/option_byte_config_loader_tb.sv ----
// Purpose: Self-checking bench for the option byte loader
// Assumes: Flash model answers reads with a chosen latency
// Notes: Each test is a full reset and reload
`timescale 1ns/10ps
`default_nettype none
module option_byte_config_loader_tb;
    import obcl_pkg::*;
    logic core_clk = 1'b0, rstn = 1'b0, boot_swap = 1'b0, ext_programmer = 1'b0;
    logic [3:0] lat = 4'h0;
    obcl_req_t rd_req;
    obcl_cfg_t cfg;
    logic rd_valid, wr_req, cfg_ready, reserved_error, poc_write_reject;
    logic [7:0] rd_data, wr_data, wr_cap;
    logic [15:0] wr_addr, addrs[$];
    int error_cnt = 0, checks = 0, wr_seen = 0, rej_seen = 0;
    always #4 core_clk = ~core_clk;
    obcl_loader u_obcl_loader(.core_clk(core_clk), .rstn(rstn), .boot_swap(boot_swap),
        .ext_programmer(ext_programmer), .rd_valid(rd_valid), .rd_data(rd_data),
        .rd_req(rd_req), .wr_req(wr_req), .wr_addr(wr_addr), .wr_data(wr_data), .cfg(cfg),
        .cfg_ready(cfg_ready), .reserved_error(reserved_error),
        .poc_write_reject(poc_write_reject));
    obcl_flash u_obcl_flash(.core_clk(core_clk), .rstn(rstn), .rd_req(rd_req), .lat(lat),
        .rd_valid(rd_valid), .rd_data(rd_data));
    // Record reads, copy pulses and refusals
    always @(posedge core_clk) begin
        if (rd_req.valid === 1'b1) addrs.push_back(rd_req.addr);
        if (wr_req === 1'b1) begin
            wr_seen++;
            wr_cap = wr_data;
        end
        if (poc_write_reject === 1'b1) rej_seen++;
    end
    task chk_val(string what, logic [15:0] exp, logic [15:0] got);
        checks++;
        if (got !== exp) begin
            error_cnt++;
            $display("MISMATCH %s expected %h seen %h", what, exp, got);
        end
    endtask
    task chk_cfg(logic [7:0] b0, logic [7:0] b1);
        obcl_cfg_t exp;
        exp = {b0[0], b0[3:1], b0[4], b0[6:5], b1[0]};
        checks++;
        if (cfg !== exp) begin
            error_cnt++;
            $display("MISMATCH cfg expected %h seen %h", exp, cfg);
        end
    endtask
    // Fill both banks, reset, wait for the load, check read count, first and last address, config and reserved flag
    task load(logic sw, logic prog, logic [7:0] b0, logic [7:0] b1, logic [7:0] b2,
            logic [3:0] l);
        int n;
        u_obcl_flash.mem[sw] = '{b0, b1, b2, 8'h00, 8'h3C};
        u_obcl_flash.mem[!sw] = '{b0, ~b1, 8'h00, 8'h00, 8'hC3};
        @(posedge core_clk);
        #1 rstn = 1'b0;
        {boot_swap, ext_programmer, lat} = {sw, prog, l};
        addrs.delete();
        {wr_seen, rej_seen} = 0;
        repeat (3) @(posedge core_clk);
        #1 rstn = 1'b1;
        for (n = 0; n < 300 && cfg_ready !== 1'b1; n++) @(posedge core_clk);
        repeat (3) @(posedge core_clk);
        #1 chk_val("ready", 16'h1, 16'(cfg_ready));
        chk_val("reads", 16'h5, 16'(addrs.size()));
        chk_val("first", {3'h0, sw, 12'h080}, addrs[0]);
        chk_val("last", {3'h0, sw, 12'h084}, addrs[addrs.size()-1]);
        chk_cfg(b0, b1);
        chk_val("reserr", 16'(b2 != 8'h00), 16'(reserved_error));
    endtask
    task report_and_stop;
        $display("checks %0d mismatches %0d", checks, error_cnt);
        if (error_cnt == 0 && checks > 0) $display("Simulation passed");
        else $display("Simulation failed");
        $finish;
    endtask
    initial begin
        #100000 error_cnt++;
        report_and_stop();
    end
    initial begin
        load(1'b0, 1'b0, 8'h5B, 8'h01, 8'h00, 4'h0);
        chk_val("nocopy", 16'h0, 16'(wr_seen + rej_seen));
        $display("test normal prompt done");
        load(1'b0, 1'b1, 8'h24, 8'h00, 8'h00, 4'h9);
        u_obcl_flash.mem[0] = '{8'h00, 8'h01, 8'h00, 8'h00, 8'h00};
        repeat (20) @(posedge core_clk);
        #1 chk_cfg(8'h24, 8'h00);
        $display("test normal slow held done");
        load(1'b1, 1'b1, 8'h6D, 8'h01, 8'h00, 4'h3);
        chk_val("copies", 16'h1, 16'(wr_seen));
        chk_val("copydata", 16'h01, 16'(wr_cap));
        chk_val("copyaddr", OBCL_ADDR_POC, wr_addr);
        $display("test swap programmer done");
        load(1'b1, 1'b0, 8'h12, 8'h00, 8'h00, 4'h1);
        chk_val("rejects", 16'h1, 16'(rej_seen));
        chk_val("copies", 16'h0, 16'(wr_seen));
        $display("test swap refused done");
        load(1'b0, 1'b0, 8'h7F, 8'h01, 8'h10, 4'h2);
        $display("test reserved byte done");
        report_and_stop();
    end
endmodule // option_byte_config_loader_tb
`default_nettype wire
